// ===== hw/tape_remote_map.vh
// Constants of the tape remote select logic: register offsets, field positions,
// reset values, pin vector positions and timing figures.
// Assumes a 25 MHz system clock and a classic Wishbone slave with 32-bit data.
//
// Operation
// RULE1: free ~400 Hz oscillator drives binary counter; low three bits are channel clock.
// RULE2: monitor and record/ready status sent time-multiplexed, one slot per channel.
// RULE3: monitor code replay,line: 00 mute, 01 line, 10 replay, 11 sync.
// RULE4: command and channel latches store inverse of the transmitted monitor code.
// RULE5: three monitor mode buttons set the two-bit monitor command latch.
// RULE6: channel button encoded to number copies command latch; no button, no change.
// RULE7: each channel's stored monitor pair is output in its channel clock slot.
// RULE8: toggling master latch bypasses scan, sends command latch code in every slot.
// RULE9: mute request from spool commands forces output code 00 over everything.
// RULE10: channel monitor code decoded onto LED matrix, column enabled in its slot.
// RULE11: monitor command latch decoded to light one matching master indicator.
// RULE12: eight record/ready latches, each toggling on its switch press.
// RULE13: record/ready latch of current slot driven onto record/ready bus wire.
// RULE14: ready LED off when clear, flashing when ready, steady with record-on.
// RULE15: record latch sets only with record button, play button and play mode.
// RULE16: record latch clears on transport command, record without play, search zero. Code clears on search zero only with play mode off.
// RULE17: search selection leaves record latch set; search-to-play resumes recording.
// RULE18: record lamp flashes until pinch engaged, then record-on asserted, lamp steady.
// RULE19: search latch set by search command, cleared by zero or stop.
// RULE20: position saturates above one minute, else 8-bit word from counter.
// RULE21: speed decision becomes spool left or right by sign; released when idle.
// RULE22: machine supplies 60 Hz motion pulses at 15 ips and forward-high direction.
// RULE23: up/down counter flags zero and reverses count direction crossing zero.
// RULE24: speed measured by counting motion pulses over fixed window, compared to position.
`ifndef TAPE_REMOTE_MAP_VH
`define TAPE_REMOTE_MAP_VH

// ****************************************
// timing
// ****************************************
`define CLK_HZ          25000000
`define OSC_HZ          400
`define READY_HZ        1
`define MOTION_HZ       60
`define SPEED_WIN_MS    250

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_MONITOR     4'h8
`define REG_POSITION    4'hC

// ****************************************
// fields
// ****************************************
`define CTRL_SOFT_MUTE  0
`define CTRL_CNT_CLEAR  1
`define ST_CHCLK        0
`define ST_MASTER       3
`define ST_REC_LATCH    4
`define ST_REC_ON       5
`define ST_SEARCH       6
`define ST_ZERO         7
`define ST_NEG          8
`define MON_CMD         0
`define MON_RR          8
`define POS_MAG         0
`define POS_NEG         16
`define POS_SPEED       24

// ****************************************
// reset values
// ****************************************
`define MON_RESET_N     2'h2
`define CTRL_RESET      2'h0

// ****************************************
// pin vector positions
// ****************************************
`define PIN_W           30
`define PIN_CHSEL       0
`define PIN_RR          8
`define PIN_MON         16
`define PIN_MASTER      19
`define PIN_REC         20
`define PIN_PLAY        21
`define PIN_PLAYMODE    22
`define PIN_XPORT       23
`define PIN_STOP        24
`define PIN_SEARCH      25
`define PIN_PINCH       26
`define PIN_MUTE        27
`define PIN_MOTION      28
`define PIN_DIR         29

`endif

// ===== hw/tape_remote_select_logic.v
// Remote unit logic: channel clock, monitor and record/ready multiplexing,
// record latch, tape counter and search-to-zero spool control.
// Assumes all pins are asynchronous to clk_i and a classic Wishbone master.
`timescale 1ns/10ps
`include "tape_remote_map.vh"

module tape_remote_select_logic #(
    parameter OSC_DIV        = `CLK_HZ / `OSC_HZ,
    parameter READY_HALF     = `CLK_HZ / (2 * `READY_HZ),
    parameter SPEED_WIN      = (`CLK_HZ / 1000) * `SPEED_WIN_MS,
    parameter PULSES_PER_SEC = `MOTION_HZ
)(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [7:0]  chan_sel_btn_i,
    input  wire [7:0]  rec_ready_sw_i,
    input  wire [2:0]  mon_mode_btn_i,
    input  wire        master_btn_i,
    input  wire        rec_btn_i,
    input  wire        play_btn_i,
    input  wire        play_mode_i,
    input  wire        transport_cmd_i,
    input  wire        stop_cmd_i,
    input  wire        search_cmd_i,
    input  wire        pinch_i,
    input  wire        mute_req_i,
    input  wire        motion_i,
    input  wire        direction_i,
    output reg  [2:0]  chan_clk_o,
    output reg         mon_replay_o,
    output reg         mon_line_o,
    output reg         rec_ready_bus_o,
    output reg         rec_on_o,
    output reg         rec_lamp_o,
    output reg  [7:0]  led_col_o,
    output reg  [3:0]  led_row_o,
    output reg  [3:0]  master_led_o,
    output reg  [7:0]  rec_ready_led_o,
    output reg         spool_left_o,
    output reg         spool_left_oe_n_o,
    output reg         spool_right_o,
    output reg         spool_right_oe_n_o
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [`PIN_W-1:0] pin_raw;
    reg  [`PIN_W-1:0] pin_s1;
    reg  [`PIN_W-1:0] pin_s2;
    reg  [`PIN_W-1:0] pin_s3;
    reg  [`PIN_W-1:0] pin;
    reg  [`PIN_W-1:0] pin_d;
    wire [`PIN_W-1:0] press;

    assign pin_raw = {direction_i, motion_i, mute_req_i, pinch_i, search_cmd_i, stop_cmd_i,
                      transport_cmd_i, play_mode_i, play_btn_i, rec_btn_i, master_btn_i,
                      mon_mode_btn_i, rec_ready_sw_i, chan_sel_btn_i};
    assign press = pin & ~pin_d;

    // a bit only moves once the second and third stages agree
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1 <= {`PIN_W{1'b0}};
            pin_s2 <= {`PIN_W{1'b0}};
            pin_s3 <= {`PIN_W{1'b0}};
            pin    <= {`PIN_W{1'b0}};
            pin_d  <= {`PIN_W{1'b0}};
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin    <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin & (pin_s2 ^ pin_s3));
            pin_d  <= pin;
        end
    end

    // ****************************************
    // oscillator, channel clock, ready wave
    // ****************************************
    reg [31:0] osc_cnt;
    reg [2:0]  chan;
    reg [31:0] ready_cnt;
    reg        ready_wave;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_cnt    <= 32'h0;
            chan       <= 3'h0;
            ready_cnt  <= 32'h0;
            ready_wave <= 1'b0;
        end
        else
        begin
            if (osc_cnt == OSC_DIV - 1)
            begin
                osc_cnt <= 32'h0;
                chan    <= chan + 3'h1; // RULE1
            end
            else
                osc_cnt <= osc_cnt + 32'h1;
            if (ready_cnt == READY_HALF - 1)
            begin
                ready_cnt  <= 32'h0;
                ready_wave <= ~ready_wave;
            end
            else
                ready_cnt <= ready_cnt + 32'h1;
        end
    end

    // ****************************************
    // monitor command and channel latches
    // ****************************************
    reg  [1:0]  cmd_n;
    reg         master;
    reg  [2:0]  sel_num;
    reg         sel_any;
    reg  [1:0]  chan_n [0:7];
    reg  [7:0]  rr;
    reg  [1:0]  soft_ctrl;
    integer     k;

    always @*
    begin
        sel_num = 3'h0;
        sel_any = 1'b0;
        for (k = 7; k >= 0; k = k - 1)
        begin
            if (pin[`PIN_CHSEL + k])
            begin
                sel_num = k[2:0];
                sel_any = 1'b1;
            end
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_n  <= `MON_RESET_N;
            master <= 1'b0;
        end
        else
        begin
            // inverted storage of the code
            if (pin[`PIN_MON + 2])
                cmd_n <= ~2'h3; // RULE5 RULE4
            else if (pin[`PIN_MON + 1])
                cmd_n <= ~2'h2; // RULE5
            else if (pin[`PIN_MON])
                cmd_n <= ~2'h1; // RULE5
            if (press[`PIN_MASTER])
                master <= ~master; // RULE8
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : per_chan
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    chan_n[g] <= `MON_RESET_N;
                    rr[g]     <= 1'b0;
                end
                else
                begin
                    if (sel_any && sel_num == g)
                        chan_n[g] <= cmd_n; // RULE6 RULE4
                    if (press[`PIN_RR + g])
                        rr[g] <= ~rr[g]; // RULE12
                end
            end
        end
    endgenerate

    // ****************************************
    // tape counter
    // ****************************************
    reg  [11:0] mag;
    reg         neg;
    reg  [7:0]  sub;
    wire        zero;
    wire        fwd;
    wire        tick;

    assign zero = (mag == 12'h0);
    assign fwd  = pin[`PIN_DIR];
    assign tick = press[`PIN_MOTION] && (sub == PULSES_PER_SEC - 1);

    always @(posedge clk_i)
    begin
        if (rst_i || (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                      && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_CNT_CLEAR]))
        begin
            mag <= 12'h0;
            neg <= 1'b0;
            sub <= 8'h0;
        end
        else if (press[`PIN_MOTION])
        begin
            sub <= tick ? 8'h0 : sub + 8'h1; // RULE22
            if (tick)
            begin
                // counting flips from down to up at zero
                if (zero)
                begin
                    mag <= 12'h1; // RULE23
                    neg <= ~fwd; // RULE23
                end
                else if (fwd ^ neg)
                    mag <= mag + 12'h1;
                else
                    mag <= mag - 12'h1;
            end
        end
    end

    // ****************************************
    // speed measure and search
    // ****************************************
    reg  [31:0] win_cnt;
    reg  [7:0]  pulse_cnt;
    reg  [7:0]  speed;
    reg         search;
    reg         rec_latch;
    wire [7:0]  pos_word;
    wire        speed_up;
    wire        spool_drive;

    assign pos_word    = (mag >= 12'd60) ? 8'hFF : {mag[5:0], 2'h0}; // RULE20
    assign speed_up    = (speed < pos_word); // RULE24
    assign spool_drive = search && !zero;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            win_cnt   <= 32'h0;
            pulse_cnt <= 8'h0;
            speed     <= 8'h0;
        end
        else if (win_cnt == SPEED_WIN - 1)
        begin
            win_cnt   <= 32'h0;
            speed     <= pulse_cnt; // RULE24
            pulse_cnt <= 8'h0;
        end
        else
        begin
            win_cnt <= win_cnt + 32'h1;
            if (press[`PIN_MOTION] && pulse_cnt != 8'hFF)
                pulse_cnt <= pulse_cnt + 8'h1;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            search    <= 1'b0;
            rec_latch <= 1'b0;
        end
        else
        begin
            if (pin[`PIN_STOP] || (search && zero))
                search <= 1'b0; // RULE19
            else if (pin[`PIN_SEARCH])
                search <= 1'b1; // RULE19
            // selecting search never clears it; only search reaching zero with play mode off does
            if (pin[`PIN_REC] && pin[`PIN_PLAY] && pin[`PIN_PLAYMODE])
                rec_latch <= 1'b1; // RULE15
            else if (pin[`PIN_XPORT] || (pin[`PIN_REC] && !pin[`PIN_PLAY])
                     || (search && zero && !pin[`PIN_PLAYMODE]))
                rec_latch <= 1'b0; // RULE16 RULE17
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    reg [1:0] code;

    always @*
    begin
        if (pin[`PIN_MUTE] || soft_ctrl[`CTRL_SOFT_MUTE])
            code = 2'h0; // RULE9
        else if (master)
            code = ~cmd_n; // RULE8
        else
            code = ~chan_n[chan]; // RULE7
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chan_clk_o         <= 3'h0;
            mon_replay_o       <= 1'b0;
            mon_line_o         <= 1'b0;
            rec_ready_bus_o    <= 1'b0;
            rec_on_o           <= 1'b0;
            rec_lamp_o         <= 1'b0;
            led_col_o          <= 8'h0;
            led_row_o          <= 4'h0;
            master_led_o       <= 4'h0;
            rec_ready_led_o    <= 8'h0;
            spool_left_o       <= 1'b0;
            spool_right_o      <= 1'b0;
            spool_left_oe_n_o  <= 1'b1;
            spool_right_oe_n_o <= 1'b1;
        end
        else
        begin
            chan_clk_o      <= chan; // RULE1
            mon_replay_o    <= code[1]; // RULE2 RULE3
            mon_line_o      <= code[0]; // RULE2 RULE3
            rec_ready_bus_o <= rr[chan]; // RULE13 RULE2
            rec_on_o        <= rec_latch && pin[`PIN_PINCH]; // RULE18
            rec_lamp_o      <= rec_latch && (pin[`PIN_PINCH] || ready_wave); // RULE18
            led_col_o       <= 8'h1 << chan; // RULE10
            led_row_o       <= 4'h1 << code; // RULE10
            master_led_o    <= 4'h1 << ~cmd_n; // RULE11
            rec_ready_led_o <= rr & {8{rec_latch && pin[`PIN_PINCH] || ready_wave}}; // RULE14
            // toward zero when speeding up, away to brake when slowing
            spool_left_o       <= spool_drive && (speed_up ^ neg); // RULE21
            spool_right_o      <= spool_drive && !(speed_up ^ neg); // RULE21
            spool_left_oe_n_o  <= !spool_drive; // RULE21
            spool_right_oe_n_o <= !spool_drive; // RULE21
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    wire bus_req;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0;
            soft_ctrl <= `CTRL_RESET;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0;
            if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL)
                soft_ctrl <= {1'b0, wb_dat_i[`CTRL_SOFT_MUTE]};
            if (bus_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `REG_CTRL:
                        wb_dat_o <= {30'h0, soft_ctrl};
                    `REG_STATUS:
                        wb_dat_o <= {23'h0, neg, zero, search, rec_on_o, rec_latch, master, chan};
                    `REG_MONITOR:
                        wb_dat_o <= {16'h0, rr, 6'h0, ~cmd_n};
                    `REG_POSITION:
                        wb_dat_o <= {speed, 7'h0, neg, 4'h0, mag};
                    default:
                        wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule

// ===== tb/tape_remote_checker.sv
// Concurrent checks on the ports of the tape remote select logic.
// Assumes clk_i with synchronous active-high rst_i; bound by port name.
`timescale 1ns/10ps
module tape_remote_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire [2:0] chan_clk_o,
    input wire       mon_replay_o,
    input wire       mon_line_o,
    input wire [7:0] led_col_o,
    input wire [3:0] led_row_o,
    input wire [3:0] master_led_o,
    input wire       mute_req_i,
    input wire       pinch_i,
    input wire       transport_cmd_i,
    input wire       play_btn_i,
    input wire       stop_cmd_i,
    input wire       rec_on_o,
    input wire       rec_lamp_o,
    input wire       rec_ready_bus_o,
    input wire [7:0] rec_ready_led_o,
    input wire       spool_left_o,
    input wire       spool_left_oe_n_o,
    input wire       spool_right_o,
    input wire       spool_right_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chan_step_a: assert property ($changed(chan_clk_o) |-> chan_clk_o == $past(chan_clk_o) + 3'h1)
        else $error("channel clock skipped a slot");
    slot_col_a: assert property (!$past(rst_i) |-> led_col_o == (8'h01 << chan_clk_o))
        else $error("column does not match slot");
    row_onehot_a: assert property (!$past(rst_i) |-> $onehot(led_row_o))
        else $error("row decode not one-hot");
    master_led_a: assert property (!$past(rst_i) |-> $onehot(master_led_o))
        else $error("master indicator not one-hot");
    mute_code_a: assert property (mute_req_i [*7] |-> !mon_replay_o && !mon_line_o)
        else $error("mute did not force code 00");
    rec_on_pinch_a: assert property (!pinch_i [*6] |-> !rec_on_o)
        else $error("record-on without pinch");
    lamp_steady_a: assert property (rec_on_o && $past(rec_on_o) |-> rec_lamp_o)
        else $error("record lamp not steady");
    xport_clear_a: assert property ((transport_cmd_i && !play_btn_i) [*8] |-> !rec_on_o)
        else $error("transport did not drop record");
    stop_release_a: assert property (stop_cmd_i [*8] |-> spool_left_oe_n_o && spool_right_oe_n_o)
        else $error("spool still driven after stop");
    spool_sign_a: assert property (!spool_left_oe_n_o |-> spool_left_o != spool_right_o)
        else $error("spool commands not exclusive");
    ready_off_a: assert property (!$past(rst_i) && !rec_ready_bus_o |-> !rec_ready_led_o[chan_clk_o])
        else $error("ready led lit while clear");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single pulse");

    cover property (rec_on_o && rec_lamp_o);
    cover property (!spool_left_oe_n_o);
    cover property (mute_req_i [*7]);
endmodule
bind tape_remote_select_logic tape_remote_checker chk (.*);

// ===== tb/tape_machine_model.sv
// Machine side: play mode, pinch report, motion pulse bursts, direction.
// Assumes the bench clock on clk_i; motion runs only during a burst.
`timescale 1ns/10ps
module tape_machine_model #(
    parameter PINCH_DLY = 40,
    parameter BURST     = 10
)(
    input  wire  clk_i,
    input  wire  play_req_i,
    input  wire  burst_i,
    input  wire  dir_i,
    output logic play_mode_o,
    output logic pinch_o,
    output logic motion_o,
    output logic direction_o
);
    integer wait_cnt = 0;
    integer left     = 0;
    logic   burst_d  = 1'h0;
    initial
    begin
        play_mode_o = 1'h0;
        pinch_o = 1'h0;
        motion_o = 1'h0;
        direction_o = 1'h1;
    end
    // pinch engages only after the capstan settles, so record-on must wait
    always @(posedge clk_i)
    begin
        play_mode_o <= play_req_i;
        wait_cnt <= play_req_i ? wait_cnt + 1 : 0;
        pinch_o <= play_req_i && wait_cnt >= PINCH_DLY;
    end
    // scaled motion train, 320 ns period, idle low between bursts
    // moves only just after a clock edge, never racing the sampling edge
    always @(posedge clk_i)
    begin
        burst_d     <= burst_i;
        left        <= (burst_i && !burst_d) ? BURST * 8 : (left > 0 ? left - 1 : 0);
        motion_o    <= left > 0 && (left - 1) % 8 >= 4;
        direction_o <= dir_i;
    end
endmodule

// ===== tb/tb_tape_remote_select_logic.sv
// Self-checking bench of the tape remote select logic with a machine model.
// Assumes scaled-down counts; expectations are literals or come from mode_code and onehot.
`timescale 1ns/10ps
module tb_tape_remote_select_logic;
    logic        clk_i = 1'h0, rst_i = 1'h1;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, q;
    logic        wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic [7:0]  chan_sel_btn_i = 8'h00, rec_ready_sw_i = 8'h00;
    logic [2:0]  mon_mode_btn_i = 3'h0;
    logic        master_btn_i = 1'h0, rec_btn_i = 1'h0, play_btn_i = 1'h0, transport_cmd_i = 1'h0, dir = 1'h1;
    logic        stop_cmd_i = 1'h0, search_cmd_i = 1'h0, mute_req_i = 1'h0, play_req = 1'h0, burst = 1'h0;
    wire         play_mode_i, pinch_i, motion_i, direction_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, mon_replay_o, mon_line_o, rec_ready_bus_o, rec_on_o, rec_lamp_o;
    wire  [2:0]  chan_clk_o;
    wire  [7:0]  led_col_o, rec_ready_led_o;
    wire  [3:0]  led_row_o, master_led_o;
    wire         spool_left_o, spool_left_oe_n_o, spool_right_o, spool_right_oe_n_o;
    integer      mismatches = 0, samples_checked = 0, cycles = 0;
    int          k, r, i, n;

    tape_remote_select_logic #(.OSC_DIV(8), .READY_HALF(16), .SPEED_WIN(64), .PULSES_PER_SEC(2)) uut (.*);
    tape_machine_model #(.PINCH_DLY(100)) mach (.clk_i(clk_i), .play_req_i(play_req), .burst_i(burst),
        .dir_i(dir), .play_mode_o(play_mode_i), .pinch_o(pinch_i), .motion_o(motion_i),
        .direction_o(direction_i));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: timeout cycles %h expected %h", $time, cycles, 0);
            test_done;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function logic [1:0] mode_code(input int m);
        return 2'(m + 1);
    endfunction
    function logic [31:0] onehot(input int b);
        return 32'h1 << b;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task hold(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    begin
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk_i);
        // only wb_ack_o or the bench timeout ends this wait
        while (wb_ack_o !== 1'h1)
            @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    end
    endtask
    task press_mode(input int m);
    begin
        @(posedge clk_i);
        mon_mode_btn_i <= 3'(1 << m);
        hold(8);
        mon_mode_btn_i <= 3'h0;
        hold(8);
    end
    endtask
    task at_slot(input int s);
        int w;
    begin
        w = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            w = w + 1;
        end
        while (chan_clk_o !== 3'(s) && w < 100);
    end
    endtask
    task rec_press(input logic play);
    begin
        @(posedge clk_i);
        rec_btn_i <= 1'h1;
        play_btn_i <= play;
        hold(8);
        rec_btn_i <= 1'h0;
        play_btn_i <= 1'h0;
        hold(4);
    end
    endtask
    // flash shows as a mix of lit and dark samples over 40 cycles
    task rr_toggle(output int c);
    begin
        c = 0;
        @(posedge clk_i);
        rec_ready_sw_i <= 8'h01 << r;
        hold(8);
        rec_ready_sw_i <= 8'h00;
        hold(8);
        repeat (40)
        begin
            @(posedge clk_i);
            #1;
            c = c + rec_ready_led_o[r];
        end
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        void'($urandom(32'hD303));
        hold(6);
        rst_i <= 1'h0;
        wb(1'h0, 4'h4, 32'h0);
        chk(q[7], 1'h1);
        for (i = 0; i < 3; i++)
        begin
            press_mode(i);
            wb(1'h0, 4'h8, 32'h0);
            chk(q[1:0], mode_code(i));
            chk(master_led_o, onehot(mode_code(i)));
        end
        k = $urandom % 8;
        press_mode(1);
        @(posedge clk_i);
        chan_sel_btn_i <= 8'h01 << k;
        hold(8);
        chan_sel_btn_i <= 8'h00;
        press_mode(2);
        at_slot(k);
        chk({mon_replay_o, mon_line_o}, 2'h2);
        chk(led_row_o, onehot(2));
        at_slot((k + 1) % 8);
        chk({mon_replay_o, mon_line_o}, 2'h1);
        chk(led_col_o, onehot((k + 1) % 8));
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk_i);
            master_btn_i <= 1'h1;
            hold(8);
            master_btn_i <= 1'h0;
            hold(8);
            at_slot(k);
            chk({mon_replay_o, mon_line_o}, i ? 2'h2 : 2'h3);
        end
        @(posedge clk_i);
        mute_req_i <= 1'h1;
        hold(10);
        at_slot(k);
        chk({mon_replay_o, mon_line_o}, 2'h0);
        @(posedge clk_i);
        mute_req_i <= 1'h0;
        wb(1'h1, 4'h0, 32'h1);
        at_slot(k);
        chk({mon_replay_o, mon_line_o}, 2'h0);
        wb(1'h1, 4'h0, 32'h0);
        wb(1'h1, 4'h6, 32'hFFFFFFFF);
        wb(1'h0, 4'h6, 32'h0);
        chk(q, 32'h0);
        at_slot(k);
        chk({mon_replay_o, mon_line_o}, 2'h2);
        r = $urandom % 8;
        for (i = 0; i < 2; i++)
        begin
            rr_toggle(n);
            chk({n == 0, n == 40}, i ? 2'h2 : 2'h0);
            wb(1'h0, 4'h8, 32'h0);
            chk(q[15:8], i ? 0 : onehot(r));
            at_slot(r);
            chk(rec_ready_bus_o, 1'(i == 0));
        end
        rec_press(1'h1);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[4], 1'h0);
        play_req <= 1'h1;
        hold(4);
        rec_press(1'h1);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[5:4], 2'h1);
        n = 0;
        repeat (40)
        begin
            @(posedge clk_i);
            #1;
            n = n + rec_lamp_o;
        end
        chk({n > 0, n < 40}, 2'h3);
        hold(60);
        chk(rec_on_o, 1'h1);
        chk(rec_lamp_o, 1'h1);
        rr_toggle(n);
        chk(n, 40);
        burst <= 1'h1;
        hold(110);
        burst <= 1'h0;
        wb(1'h0, 4'hC, 32'h0);
        chk(q[11:0], 12'h005);
        search_cmd_i <= 1'h1;
        hold(8);
        search_cmd_i <= 1'h0;
        wb(1'h0, 4'h4, 32'h0);
        chk(q[6:4], 3'h7);
        chk(spool_left_oe_n_o, 1'h0);
        chk(spool_left_o ^ spool_right_o, 1'h1);
        stop_cmd_i <= 1'h1;
        hold(10);
        stop_cmd_i <= 1'h0;
        wb(1'h0, 4'h4, 32'h0);
        chk(q[6], 1'h0);
        chk(spool_right_oe_n_o, 1'h1);
        transport_cmd_i <= 1'h1;
        hold(10);
        transport_cmd_i <= 1'h0;
        wb(1'h0, 4'h4, 32'h0);
        chk(q[5:4], 2'h0);
        rec_press(1'h1);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[4], 1'h1);
        rec_press(1'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[4], 1'h0);
        // reverse travel: down to zero, then across it into negative
        dir <= 1'h0;
        repeat (2)
        begin
            burst <= 1'h1;
            hold(110);
            burst <= 1'h0;
            hold(2);
        end
        wb(1'h0, 4'hC, 32'h0);
        chk({q[16], q[11:0]}, 13'h1005);
        wb(1'h1, 4'h0, 32'h2);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[7], 1'h1);
        test_done;
    end
endmodule
